// ===== common/hport_pkg.sv
// shared constants for the host port device and controller
package hport_pkg;
    // ========================================
    // clock and timing
    localparam int CLK_MHZ      = 50;
    localparam int PEND_NS      = 40;
    localparam int PEND_CYC     = (PEND_NS * CLK_MHZ + 999) / 1000;
    localparam int ASTB_NS      = 40;
    localparam int ASTB_CYC     = (ASTB_NS * CLK_MHZ + 999) / 1000;
    // ========================================
    // link widths
    localparam int DW           = 16;
    localparam int AW           = 18;
    localparam int MEM_AW       = 8;
    // ========================================
    // register selects on the link
    localparam logic [1:0] SEL_CTRL  = 2'h0;
    localparam logic [1:0] SEL_DATAI = 2'h1;
    localparam logic [1:0] SEL_ADDR  = 2'h2;
    localparam logic [1:0] SEL_DATA  = 2'h3;
    // host_control_reg fields
    localparam int CTL_IRQ_A    = 0;
    localparam int CTL_IRQ_B    = 1;
    localparam int CTL_TOCORE_A = 2;
    localparam int CTL_TOCORE_B = 3;
    // ========================================
    // controller APB map
    localparam logic [7:0] OFF_CMD   = 8'h00;
    localparam logic [7:0] OFF_WDATA = 8'h04;
    localparam logic [7:0] OFF_ADDR  = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0C;
    localparam logic [7:0] OFF_STAT  = 8'h10;
    localparam logic [7:0] OFF_ISTAT = 8'h14;
    localparam logic [7:0] OFF_IMASK = 8'h18;
    localparam logic [7:0] OFF_CFG   = 8'h1C;
    // cmd fields
    localparam int CMD_GO       = 0;
    localparam int CMD_READ     = 1;
    localparam int CMD_SEL      = 2;
    localparam int CMD_ASTB     = 4;
    // interrupt status fields
    localparam int IS_DONE      = 0;
    localparam int IS_IRQ_A     = 1;
    localparam int IS_IRQ_B     = 2;
    // cfg: bit0 iface_select, bit1 mux_mode_sel, bit2 port reset, bit3 output enable
    localparam logic [3:0] CFG_RST   = 4'h8;
endpackage : hport_pkg

// ===== common/hport_if.sv
// pin-level link between host controller and host port device
`timescale 1ns/100ps
interface hport_if;
    import hport_pkg::*;
    logic          iface_select;
    logic          mux_mode_sel;
    logic          port_reset_n;
    logic          output_disable_n;
    logic          host_chip_sel_n;
    logic          host_strobe_a_n;
    logic          host_strobe_b_n;
    logic          host_dir;
    logic          reg_select_lo;
    logic          reg_select_hi;
    logic          host_addr_strobe_n;
    logic [AW-1:0] host_addr;
    logic [DW-1:0] hd_host_o;
    logic          hd_host_oe;
    logic [DW-1:0] hd_dev_o;
    logic          hd_dev_oe;
    logic [DW-1:0] hd;
    logic          ready_o;
    logic          ready_oe;
    logic          host_ready_out;
    logic [1:0]    irq_o;
    logic [1:0]    irq_oe;
    logic          core_a_host_irq_n;
    logic          core_b_host_irq_n;
    // undriven pins float to the pulled-up level; data bus reads zero
    assign hd = hd_dev_oe ? hd_dev_o : (hd_host_oe ? hd_host_o : 16'h0000);
    assign host_ready_out    = ready_oe ? ready_o : 1'b1;
    assign core_a_host_irq_n = irq_oe[0] ? irq_o[0] : 1'b1;
    assign core_b_host_irq_n = irq_oe[1] ? irq_o[1] : 1'b1;
    modport dev (input iface_select, mux_mode_sel, port_reset_n, output_disable_n, host_chip_sel_n,
                 host_strobe_a_n, host_strobe_b_n, host_dir, reg_select_lo, reg_select_hi,
                 host_addr_strobe_n, host_addr, hd,
                 output hd_dev_o, hd_dev_oe, ready_o, ready_oe, irq_o, irq_oe);
    modport host (output iface_select, mux_mode_sel, port_reset_n, output_disable_n, host_chip_sel_n,
                  host_strobe_a_n, host_strobe_b_n, host_dir, reg_select_lo, reg_select_hi,
                  host_addr_strobe_n, host_addr, hd_host_o, hd_host_oe,
                  input hd, host_ready_out, core_a_host_irq_n, core_b_host_irq_n);
endinterface : hport_if

// ===== logic/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    // ========================================
    // per-bit stages
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r[i] <= RST[i];
                    q[i]      <= RST[i];
                end else begin
                    meta_r[i] <= d[i];
                    q[i]      <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync

// ===== logic/hport_device.sv
// host port device end: pin decode, port registers, shared memory, interrupts
// Operation
// R1 - register selects pick target, multiplexed mode only
// R2 - pins are host port only when select low
// R3 - address strobe latches address in multiplexed mode
// R4 - host holds chip select during each transfer
// R5 - data strobes time every transfer
// R6 - direction pin chooses read or write
// R7 - ready low while earlier access pending
// R8 - ready released when output disable low
// R9 - both interrupt pins released when disable low
// R10 - port reset clears port and both subsystems
// R11 - mux pin low gives multiplexed register access
// R12 - interrupts both ways in multiplexed mode
// R13 - mux pin high: 18-bit address, no interrupts
// R14 - interrupt driven low, host writes one clears
// R15 - host waits for ready before next strobe
`timescale 1ns/100ps
module hport_device
    import hport_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    hport_if.dev                   link,
    input  wire logic [MEM_AW-1:0] mem_addr,
    input  wire logic              mem_we,
    input  wire logic [DW-1:0]     mem_wdata,
    output logic      [DW-1:0]     mem_rdata,
    input  wire logic              core_a_irq_req,
    input  wire logic              core_b_irq_req,
    output logic                   to_core_a_irq,
    output logic                   to_core_b_irq,
    output logic                   core_a_reset,
    output logic                   core_b_reset
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACC  = 2'b01,
        ST_HOLD = 2'b10,
        ST_POST = 2'b11
    } dev_state_t;

    // ========================================
    // pin synchronisers
    localparam int NS = 10 + DW + AW;
    logic [NS-1:0] raw_w;
    logic [NS-1:0] syn_w;
    assign raw_w = {link.iface_select, link.mux_mode_sel, link.port_reset_n, link.output_disable_n,
                    link.host_chip_sel_n, link.host_strobe_a_n, link.host_strobe_b_n, link.host_dir,
                    link.reg_select_hi, link.reg_select_lo, link.hd, link.host_addr};
    pin_sync #(.W(NS), .RST({6'h3F, 4'hF, {DW{1'b0}}, {AW{1'b0}}})) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw_w),
        .q       (syn_w)
    );
    logic            iface_sel_s;
    logic            mux_sel_s;
    logic            prst_n_s;
    logic            oen_s;
    logic            cs_n_s;
    logic            sa_n_s;
    logic            sb_n_s;
    logic            dir_s;
    logic [1:0]      sel_s;
    logic [DW-1:0]   hd_s;
    logic [AW-1:0]   haddr_s;
    assign {iface_sel_s, mux_sel_s, prst_n_s, oen_s, cs_n_s, sa_n_s, sb_n_s, dir_s, sel_s, hd_s, haddr_s} = syn_w;
    // the address strobe is a pin too; own pair keeps it out of the wide group
    logic astb_n_s;
    pin_sync #(.W(1), .RST(1'b1)) u_astb (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (link.host_addr_strobe_n),
        .q       (astb_n_s)
    );

    // ========================================
    // decode
    logic          host_mode_w;
    logic          mux_mode_w;
    logic          strobe_w;
    logic          kill_w;
    assign host_mode_w = !iface_sel_s;                                         // R2
    assign mux_mode_w  = host_mode_w && !mux_sel_s;                            // R11
    // either strobe low with chip select low opens an access
    assign strobe_w    = host_mode_w && !cs_n_s && !(sa_n_s && sb_n_s);        // R5
    assign kill_w      = !prst_n_s;                                            // R10

    dev_state_t    state_r;
    dev_state_t    state_nxt;
    logic [1:0]    cnt_r;
    logic [1:0]    cnt_nxt;
    logic          dir_r;
    logic [1:0]    sel_r;
    logic          mux_r;
    logic [DW-1:0] wdat_r;
    logic [AW-1:0] xaddr_r;
    logic [AW-1:0] haddr_r;
    logic [3:0]    ctl_r;
    logic [DW-1:0] rdat_r;
    logic          astb_d_r;
    logic          astb_fall_w;
    logic          cnt_end_w;

    assign astb_fall_w = astb_d_r && !astb_n_s && mux_mode_w;                  // R3
    assign cnt_end_w   = (cnt_r == 2'(PEND_CYC - 1));

    // ========================================
    // access sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            ST_IDLE: begin
                cnt_nxt = 2'h0;
                if (strobe_w) begin
                    state_nxt = ST_ACC;                                        // R5
                end
            end
            ST_ACC: begin
                cnt_nxt = cnt_r + 2'h1;
                if (cnt_end_w) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                cnt_nxt = 2'h0;
                if (!strobe_w) begin
                    state_nxt = dir_r ? ST_IDLE : ST_POST;                     // R6
                end
            end
            ST_POST: begin
                cnt_nxt = cnt_r + 2'h1;
                if (cnt_end_w) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    logic          start_w;
    logic          commit_w;
    logic          is_data_w;
    logic          incr_w;
    logic [MEM_AW-1:0] midx_w;
    assign start_w   = (state_r == ST_IDLE) && strobe_w;
    assign commit_w  = (state_r == ST_HOLD) && !strobe_w && !dir_r;
    // in non-multiplexed mode every access goes to the data register
    assign is_data_w = !mux_r || sel_r[0];                                     // R1 R13
    assign incr_w    = mux_r && (sel_r == SEL_DATAI);
    assign midx_w    = mux_r ? haddr_r[MEM_AW-1:0] : xaddr_r[MEM_AW-1:0];     // R13

    // ========================================
    // shared memory, two ports
    logic [DW-1:0] mem_r [2**MEM_AW];
    always_ff @(posedge pclk) begin
        if (commit_w && is_data_w) begin
            mem_r[midx_w] <= wdat_r;                                           // R6
        end else if (mem_we) begin
            mem_r[mem_addr] <= mem_wdata;
        end
        mem_rdata <= mem_r[mem_addr];
    end

    // ========================================
    // port registers
    logic [3:0] ctl_set_w;
    logic [3:0] ctl_clr_w;
    logic       ctl_wr_w;
    assign ctl_wr_w  = commit_w && mux_r && (sel_r == SEL_CTRL);               // R1
    // host writes one to drop a core interrupt, one to raise a core-bound one
    assign ctl_clr_w = ctl_wr_w ? {2'b00, wdat_r[CTL_IRQ_B], wdat_r[CTL_IRQ_A]} : 4'h0;   // R14
    assign ctl_set_w = {ctl_wr_w ? wdat_r[CTL_TOCORE_B:CTL_TOCORE_A] : 2'b00,
                        mux_mode_w ? {core_b_irq_req, core_a_irq_req} : 2'b00};           // R12 R13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 2'h0;
            dir_r    <= 1'b0;
            sel_r    <= 2'h0;
            mux_r    <= 1'b0;
            wdat_r   <= 16'h0000;
            xaddr_r  <= 18'h00000;
            astb_d_r <= 1'b1;
        end else if (kill_w) begin
            state_r  <= ST_IDLE;                                               // R10
            cnt_r    <= 2'h0;
            astb_d_r <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            astb_d_r <= astb_n_s;
            if (start_w) begin
                dir_r   <= dir_s;                                              // R6
                sel_r   <= sel_s;                                              // R1
                mux_r   <= mux_mode_w;
                xaddr_r <= haddr_s;                                            // R13
            end
            if ((state_r == ST_HOLD) && !dir_r) begin
                wdat_r <= hd_s;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            haddr_r <= 18'h00000;
            ctl_r   <= 4'h0;
            rdat_r  <= 16'h0000;
        end else if (kill_w) begin
            haddr_r <= 18'h00000;
            ctl_r   <= 4'h0;
        end else begin
            if (astb_fall_w) begin
                haddr_r <= {2'b00, hd_s};                                      // R3
            end else if (commit_w && mux_r && (sel_r == SEL_ADDR)) begin
                haddr_r <= {2'b00, wdat_r};                                    // R1
            end else if ((commit_w || (state_r == ST_HOLD && !strobe_w && dir_r)) && incr_w) begin
                haddr_r <= haddr_r + 18'h00001;
            end
            // a fresh request wins over a same-cycle clear
            ctl_r <= (ctl_r & ~ctl_clr_w) | ctl_set_w;
            if ((state_r == ST_ACC) && cnt_end_w) begin
                unique case (is_data_w)
                    1'b1: rdat_r <= mem_r[midx_w];
                    1'b0: rdat_r <= (sel_r == SEL_ADDR) ? haddr_r[DW-1:0] : {12'h000, ctl_r};
                endcase
            end
        end
    end

    // ========================================
    // pins back to the host
    logic drv_w;
    assign drv_w        = host_mode_w && oen_s;
    assign link.ready_o  = (state_r == ST_IDLE) || (state_r == ST_HOLD);      // R7
    assign link.ready_oe = drv_w;                                              // R8
    assign link.hd_dev_o  = rdat_r;
    assign link.hd_dev_oe = (state_r == ST_HOLD) && dir_r && strobe_w && oen_s;
    // interrupts exist only in multiplexed mode and drive low when asserted
    assign link.irq_o  = ~ctl_r[CTL_IRQ_B:CTL_IRQ_A];                          // R14
    assign link.irq_oe = {2{drv_w && !mux_sel_s}};                             // R9 R13

    assign to_core_a_irq = ctl_r[CTL_TOCORE_A];                                // R12
    assign to_core_b_irq = ctl_r[CTL_TOCORE_B];
    assign core_a_reset  = kill_w;                                             // R10
    assign core_b_reset  = kill_w;
endmodule : hport_device

// ===== logic/hport_host.sv
// host controller end: APB register file driving the host port pins
`timescale 1ns/100ps
module hport_host
    import hport_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    hport_if.host            link
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_ASTB = 3'b001,
        H_STRB = 3'b010,
        H_REL  = 3'b011,
        H_WAIT = 3'b100
    } host_state_t;

    // ========================================
    // pin synchronisers
    logic [2:0]    syn_w;
    logic [DW-1:0] hd_s;
    pin_sync #(.W(3), .RST(3'h7)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link.host_ready_out, link.core_b_host_irq_n, link.core_a_host_irq_n}),
        .q       (syn_w)
    );
    pin_sync #(.W(DW), .RST(16'h0000)) u_dsync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (link.hd),
        .q       (hd_s)
    );
    logic rdy_s;
    assign rdy_s = syn_w[2];

    // ========================================
    // APB decode
    logic wr_w;
    logic hit_w;
    assign wr_w  = psel && penable && pwrite;
    assign hit_w = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_w;

    host_state_t   state_r;
    logic [4:0]    cmd_r;
    logic [DW-1:0] wdata_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] rdata_r;
    logic [2:0]    istat_r;
    logic [2:0]    imask_r;
    logic [3:0]    cfg_r;
    logic [1:0]    cnt_r;
    logic [1:0]    irq_d_r;
    logic [2:0]    ev_w;
    logic          go_w;
    logic          done_w;
    assign go_w   = wr_w && (paddr == OFF_CMD) && pwdata[CMD_GO] && (state_r == H_IDLE);
    assign done_w = (state_r == H_WAIT) && rdy_s;
    // falling interrupt pins are events; set beats a same-cycle clear
    assign ev_w   = {irq_d_r[1] && !syn_w[1], irq_d_r[0] && !syn_w[0], done_w};
    assign irq    = |(istat_r & imask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r   <= 5'h00;
            wdata_r <= 16'h0000;
            addr_r  <= 18'h00000;
            imask_r <= 3'h0;
            cfg_r   <= CFG_RST;
            istat_r <= 3'h0;
            irq_d_r <= 2'h3;
        end else begin
            irq_d_r <= syn_w[1:0];
            istat_r <= (istat_r & ~((wr_w && paddr == OFF_ISTAT) ? pwdata[2:0] : 3'h0)) | ev_w;
            if (wr_w && state_r == H_IDLE) begin
                unique case (paddr)
                    OFF_CMD:   cmd_r   <= pwdata[4:0];
                    OFF_WDATA: wdata_r <= pwdata[DW-1:0];
                    OFF_ADDR:  addr_r  <= pwdata[AW-1:0];
                    OFF_IMASK: imask_r <= pwdata[2:0];
                    OFF_CFG:   cfg_r   <= pwdata[3:0];
                    default:   ;
                endcase
            end else if (wr_w && paddr == OFF_IMASK) begin
                imask_r <= pwdata[2:0];
            end
        end
    end

    // ========================================
    // pin sequencer: strobe opens, ready high closes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= H_IDLE;
            cnt_r   <= 2'h0;
            rdata_r <= 16'h0000;
        end else begin
            unique case (state_r)
                H_IDLE: if (go_w) begin
                    state_r <= pwdata[CMD_ASTB] ? H_ASTB : H_STRB;
                    cnt_r   <= 2'h0;
                end
                H_ASTB: begin
                    cnt_r <= cnt_r + 2'h1;
                    if (cnt_r == 2'(ASTB_CYC - 1)) begin
                        state_r <= H_STRB;
                    end
                end
                // ready is sampled late: wait for it to drop, then to rise
                H_STRB: begin
                    cnt_r <= rdy_s ? cnt_r : 2'h3;
                    if (cnt_r == 2'h3 && rdy_s) begin
                        rdata_r <= hd_s;
                        state_r <= H_REL;
                    end
                end
                H_REL:  begin
                    state_r <= H_WAIT;
                    cnt_r   <= 2'h0;
                end
                H_WAIT: if (rdy_s) begin // R15
                    cnt_r <= cnt_r + 2'h1;
                    if (cnt_r == 2'h3) begin
                        state_r <= H_IDLE;
                    end
                end else begin
                    cnt_r <= 2'h0;
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    logic [31:0] rd_w;
    assign rd_w = (paddr == OFF_CMD)   ? {27'h0, cmd_r & 5'h1E} :
                  (paddr == OFF_WDATA) ? {16'h0, wdata_r} :
                  (paddr == OFF_ADDR)  ? {14'h0, addr_r} :
                  (paddr == OFF_RDATA) ? {16'h0, rdata_r} :
                  (paddr == OFF_STAT)  ? {31'h0, state_r != H_IDLE} :
                  (paddr == OFF_ISTAT) ? {29'h0, istat_r} :
                  (paddr == OFF_IMASK) ? {29'h0, imask_r} :
                  (paddr == OFF_CFG)   ? {28'h0, cfg_r} : 32'h0000_0000;
    assign prdata = rd_w;

    // ========================================
    // pins
    logic act_w;
    assign act_w = (state_r == H_STRB);
    assign link.iface_select       = cfg_r[0];
    assign link.mux_mode_sel       = cfg_r[1];
    assign link.port_reset_n       = !cfg_r[2];
    assign link.output_disable_n   = cfg_r[3];
    assign link.host_chip_sel_n    = !(act_w || state_r == H_ASTB); // R4
    assign link.host_strobe_a_n    = !act_w;
    assign link.host_strobe_b_n    = 1'b1;
    assign link.host_dir           = cmd_r[CMD_READ];
    assign link.reg_select_lo      = cmd_r[CMD_SEL];
    assign link.reg_select_hi      = cmd_r[CMD_SEL+1];
    assign link.host_addr_strobe_n = !(state_r == H_ASTB);
    assign link.host_addr          = addr_r;
    assign link.hd_host_o          = (state_r == H_ASTB) ? addr_r[DW-1:0] : wdata_r;
    assign link.hd_host_oe         = (state_r == H_ASTB) || (act_w && !cmd_r[CMD_READ]);
endmodule : hport_host

// ===== testbench/hport_asserts.sv
// concurrent checks on the host port link
`timescale 1ns/100ps
module hport_asserts (
    input wire logic       pclk, presetn, iface_select, mux_mode_sel, output_disable_n, port_reset_n,
    input wire logic       host_chip_sel_n, host_strobe_a_n, host_strobe_b_n, host_dir, ready_oe, hd_dev_oe,
    input wire logic [1:0] irq_oe,
    input wire logic       host_ready_out, core_a_host_irq_n, core_b_host_irq_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] idle_r;
    // cycles with both strobes idle, saturating so it never wraps
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) idle_r <= 4'h0;
        else idle_r <= (host_strobe_a_n && host_strobe_b_n) ? idle_r + {3'h0, idle_r != 4'hF} : 4'h0;
    sequence s_strobe;
        !host_chip_sel_n && $fell(host_strobe_a_n && host_strobe_b_n) && output_disable_n && !iface_select;
    endsequence
    a_rdy_release: assert property (!output_disable_n [*5] |-> !ready_oe) else $error("ready driven");
    a_irq_release: assert property (!output_disable_n [*5] |-> irq_oe == 2'h0) else $error("irq driven");
    a_mem_mode: assert property (iface_select [*5] |-> !ready_oe && !hd_dev_oe && irq_oe == 2'h0)
        else $error("pins driven in memory mode");
    a_nonmux_noirq: assert property (mux_mode_sel [*5] |-> irq_oe == 2'h0) else $error("irq in non-mux");
    a_busy_shown: assert property (s_strobe |-> ##[1:6] !host_ready_out) else $error("ready not dropped");
    a_read_drive: assert property (s_strobe ##0 host_dir |-> ##[1:12] hd_dev_oe) else $error("no read data");
    a_port_reset: assert property (!port_reset_n [*6] |-> host_ready_out && core_a_host_irq_n && core_b_host_irq_n)
        else $error("port reset not applied");
    a_ready_idle: assert property (idle_r >= 4'hC |-> host_ready_out) else $error("ready stuck low");
endmodule : hport_asserts

// ===== testbench/host_port_pin_interface_tb.sv
// self-checking bench for the host controller and port device pair
`timescale 1ns/100ps
module host_port_pin_interface_tb;
    import hport_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0]  paddr = 8'h00, mem_addr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [15:0] mem_rdata;
    logic        pready, pslverr, irq, to_a, to_b, rst_a, rst_b, req_a = 1'b0, req_b = 1'b0;
    int          bad_count = 0, n_checks = 0, seed = 32'h2A5C;
    hport_if link_if ();
    hport_device hport_device_i (.pclk(pclk), .presetn(presetn), .link(link_if), .mem_addr(mem_addr),
        .mem_we(1'b0), .mem_wdata(16'h0000), .mem_rdata(mem_rdata), .core_a_irq_req(req_a), .core_b_irq_req(req_b),
        .to_core_a_irq(to_a), .to_core_b_irq(to_b), .core_a_reset(rst_a), .core_b_reset(rst_b));
    hport_host hport_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link_if));
    hport_asserts hport_asserts_i (.pclk(pclk), .presetn(presetn), .iface_select(link_if.iface_select),
        .mux_mode_sel(link_if.mux_mode_sel), .output_disable_n(link_if.output_disable_n),
        .port_reset_n(link_if.port_reset_n), .host_chip_sel_n(link_if.host_chip_sel_n),
        .host_strobe_a_n(link_if.host_strobe_a_n), .host_strobe_b_n(link_if.host_strobe_b_n),
        .host_dir(link_if.host_dir), .ready_oe(link_if.ready_oe), .hd_dev_oe(link_if.hd_dev_oe),
        .irq_oe(link_if.irq_oe), .host_ready_out(link_if.host_ready_out),
        .core_a_host_irq_n(link_if.core_a_host_irq_n), .core_b_host_irq_n(link_if.core_b_host_irq_n));
    always #10 pclk = ~pclk;
    // ========================================
    // bus and compare helpers
    function automatic logic [31:0] cmd(input logic [1:0] s, input logic r, input logic a);
        return {27'h0, a, s, r, 1'b1};
    endfunction : cmd
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // one link transfer, then poll busy until the controller is idle
    task automatic go(input logic [31:0] c, input logic [31:0] w);
        int i = 0;
        apb(1'b1, OFF_WDATA, w); apb(1'b1, OFF_CMD, c);
        do begin apb(1'b0, OFF_STAT, 32'h0); i++; end while (rd[0] !== 1'b0 && i < 300);
        chk({31'h0, rd[0]}, 32'h0);
    endtask : go
    task automatic pulse(input int n);
        req_a <= 1'b1; req_b <= n[0]; @(posedge pclk); req_a <= 1'b0; req_b <= 1'b0; repeat (6) @(posedge pclk);
    endtask : pulse
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial begin
        #1000000; bad_count++; end_sim();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CFG, 32'h0); chk(rd, {28'h0, CFG_RST});
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 32'hFF00_FFFF : $random(seed);
            apb(1'b1, OFF_ADDR, {24'h0, d[31:24]});
            if (k[0]) go(cmd(SEL_DATA, 1'b0, 1'b1), d);
            else begin go(cmd(SEL_ADDR, 1'b0, 1'b0), {24'h0, d[31:24]}); go(cmd(SEL_DATA, 1'b0, 1'b0), d); end
            go(cmd(k[0] ? SEL_DATAI : SEL_DATA, 1'b1, 1'b0), 32'h0);
            apb(1'b0, OFF_RDATA, 32'h0); chk({16'h0, rd[15:0]}, {16'h0, d[15:0]});
            mem_addr <= d[31:24]; repeat (2) @(posedge pclk); chk({16'h0, mem_rdata}, {16'h0, d[15:0]});
        end
        $display("test transfers done");
        apb(1'b1, OFF_IMASK, 32'h2); pulse(1);
        chk({link_if.core_a_host_irq_n, link_if.core_b_host_irq_n, irq}, 3'b001);
        go(cmd(SEL_CTRL, 1'b0, 1'b0), (1 << CTL_IRQ_A) | (1 << CTL_TOCORE_B));
        chk({link_if.core_a_host_irq_n, link_if.core_b_host_irq_n, to_b}, 3'b101);
        apb(1'b1, OFF_ISTAT, 32'h3); repeat (2) @(posedge pclk); chk({31'h0, irq}, 32'h0);
        go(cmd(SEL_CTRL, 1'b0, 1'b0), 1 << CTL_IRQ_B); chk({31'h0, link_if.core_b_host_irq_n}, 32'h1);
        $display("test interrupts done");
        apb(1'b1, OFF_CFG, 32'hA); repeat (4) @(posedge pclk); pulse(0);
        chk({31'h0, link_if.core_a_host_irq_n}, 32'h1);
        apb(1'b1, OFF_CFG, 32'h8); repeat (4) @(posedge pclk); pulse(0);
        chk({31'h0, link_if.core_a_host_irq_n}, 32'h0);
        apb(1'b1, OFF_CFG, 32'h0); repeat (5) @(posedge pclk);
        chk({link_if.core_a_host_irq_n, link_if.host_ready_out}, 2'b11);
        apb(1'b1, OFF_CFG, 32'hC); repeat (5) @(posedge pclk);
        chk({rst_a, rst_b, to_b}, 3'b110);
        apb(1'b1, OFF_CFG, 32'h9); repeat (6) @(posedge pclk);
        apb(1'b1, OFF_CFG, 32'h8); apb(1'b0, 8'h20, 32'h0); chk({31'h0, er}, 32'h1);
        $display("test modes done");
        end_sim();
    end
endmodule : host_port_pin_interface_tb
